// ==== rtl/cprc_pkg.sv ====
// Constants and types for the config PROM readout control block
package cprc_pkg;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int MCLK_NS      = 25;
    localparam int OSC_HALF_NS  = 100;
    localparam int OSC_HALF_CYC = (OSC_HALF_NS + MCLK_NS - 1) / MCLK_NS;
    localparam int RST_HOLD_NS  = 1000;
    localparam int RST_HOLD_CYC = (RST_HOLD_NS + MCLK_NS - 1) / MCLK_NS;
    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] CTRL_OFS  = 8'h00;
    localparam logic [7:0] TERM_OFS  = 8'h04;
    localparam logic [7:0] MADDR_OFS = 8'h08;
    localparam logic [7:0] MDATA_OFS = 8'h0c;
    localparam logic [7:0] STAT_OFS  = 8'h10;
    // Control fields and reset values
    localparam int CTRL_W          = 6;
    localparam int CTRL_REV_LSB    = 0;
    localparam int CTRL_FWD_BIT    = 2;
    localparam int CTRL_EXT_BIT    = 3;
    localparam int CTRL_SER_BIT    = 4;
    localparam int CTRL_DEC_BIT    = 5;
    localparam logic [5:0] CTRL_RST = 6'h04;
    // Status fields
    localparam int STAT_REV_LSB    = 16;
    localparam int STAT_CHAIN_BIT  = 18;
    localparam int STAT_ACT_BIT    = 19;
    // ----------------------------------------
    // Test access port
    // ----------------------------------------
    localparam int IR_W = 8;
    localparam logic [7:0]  IR_IDCODE  = 8'h01;
    localparam logic [7:0]  IR_BYPASS  = 8'hff;
    localparam logic [7:0]  IR_CAPTURE = 8'h01;
    // Arbitrary identification value
    localparam logic [31:0] ID_VALUE   = 32'h0a5a_5001;
    typedef enum logic [15:0] {
        TAP_TLR = 16'h0001, TAP_RTI = 16'h0002, TAP_SDR = 16'h0004,
        TAP_CDR = 16'h0008, TAP_HDR = 16'h0010, TAP_E1D = 16'h0020,
        TAP_PDR = 16'h0040, TAP_E2D = 16'h0080, TAP_UDR = 16'h0100,
        TAP_SIR = 16'h0200, TAP_CIR = 16'h0400, TAP_HIR = 16'h0800,
        TAP_E1I = 16'h1000, TAP_PIR = 16'h2000, TAP_E2I = 16'h4000,
        TAP_UIR = 16'h8000
    } cprc_tap_type;
    // Control register carrier
    typedef struct packed {
        logic       decomp;
        logic       serial;
        logic       ext_clk;
        logic       fwd_en;
        logic [1:0] rev;
    } cprc_ctrl_type;
endpackage : cprc_pkg

// ==== rtl/cprc_top.sv ====
// Config PROM readout: FIFO and top level
//
// Overview of operation
// - chain_enable_out_n low only when selected, not reset, counter past terminal.
// - chain_enable_out_n returns high on reset low or chip enable high.
// - external_revision_pick_n low takes revision from revision pins.
// - external_revision_pick_n high takes revision from internal bits.
// - Revision pins form a two-bit index overriding internal bits.
// - Parallel mode busy high freezes counter and holds data.
// - First clock edge after busy falls drives next address data.
// - Busy ignored in serial mode or with decompression.
// - Internal bit enables forwarded clock from selected source.
// - Counter advances on source edge (every eighth edge in serial mode) with data, selected, not reset.
// - Data changes with the rising edge of the forwarded clock.
// - Forwarded clock floats when unselected or held in reset.
// - With decompression, forwarded clock stops while data not ready.
// - Mode select sampled on each test clock rising edge.
// - Test clock sequences the test port and its registers.
// - Test data input shifts into selected instruction or data register.
// - Chip enable high resets counter and floats outputs.
// - Reset line low resets counter and floats; device drives it low in reset.
// - Config pulse rising edge latches revision and restarts at its base.
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module cprc_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    // Clock and reset
    input  wire logic         i_mclk,
    input  wire logic         i_rst,
    input  wire logic         i_clk_en,
    input  wire logic         i_flush,
    // Fill side
    input  wire logic         i_in_valid,
    output logic              o_in_ready,
    input  wire logic [W-1:0] i_in_data,
    // Drain side
    output logic              o_out_valid,
    input  wire logic         i_out_ready,
    output logic [W-1:0]      o_out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem_reg [D];
    logic [AW-1:0] wp_reg, rp_reg;
    logic [AW:0]   cnt_reg;
    wire push = i_in_valid & o_in_ready;
    wire pop  = o_out_valid & i_out_ready;
    assign o_in_ready  = (cnt_reg != (AW+1)'(D));
    assign o_out_valid = (cnt_reg != '0);
    assign o_out_data  = mem_reg[rp_reg];
    // Storage write
    always_ff @(posedge i_mclk) begin
        if (i_clk_en && push && !i_flush) begin
            mem_reg[wp_reg] <= i_in_data;
        end
    end
    // Pointers and fill level
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            wp_reg  <= '0;
            rp_reg  <= '0;
            cnt_reg <= '0;
        end else if (i_clk_en) begin
            if (i_flush) begin
                wp_reg  <= '0;
                rp_reg  <= '0;
                cnt_reg <= '0;
            end else begin
                wp_reg  <= push ? AW'(wp_reg + 1'b1) : wp_reg;
                rp_reg  <= pop ? AW'(rp_reg + 1'b1) : rp_reg;
                cnt_reg <= (AW+1)'(cnt_reg + push - pop);
            end
        end
    end
endmodule : cprc_fifo

module cprc_top
    import cprc_pkg::*;
#(
    parameter int MAW      = 12,
    parameter int FIFO_D   = 16,
    parameter int TERM_RST = 4095
) (
    // Clock, clock enable, reset
    input  wire logic        i_mclk,
    input  wire logic        i_clk_en,
    input  wire logic        i_rst,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Configuration pins
    input  wire logic        i_cfg_clk,
    input  wire logic        i_chip_en_n,
    input  wire logic        i_oe_rst_n,
    output logic             o_oe_rst_n_out,
    output logic             o_oe_rst_oe,
    input  wire logic        i_busy,
    input  wire logic        i_config_pulse_n,
    input  wire logic        i_external_revision_pick_n,
    input  wire logic        i_revision_pin_bit0,
    input  wire logic        i_revision_pin_bit1,
    output logic [7:0]       o_data,
    output logic [7:0]       o_data_oe,
    output logic             o_forwarded_config_clock,
    output logic             o_forwarded_config_clock_oe,
    output logic             o_chain_enable_out_n,
    // Test port
    input  wire logic        i_tck,
    input  wire logic        i_tms,
    input  wire logic        i_tdi,
    output logic             o_tdo,
    output logic             o_tdo_oe
);
    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    localparam int NS = 11;
    wire [NS-1:0] async_in = {i_cfg_clk, i_tck, i_tms, i_tdi, i_busy,
                              i_config_pulse_n, i_external_revision_pick_n,
                              i_revision_pin_bit1, i_revision_pin_bit0,
                              i_chip_en_n, i_oe_rst_n};
    logic [NS-1:0] s1_reg, s2_reg;
    logic [2:0]    prev_reg;
    // Two-stage sync, edge history
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            s1_reg   <= 11'h1bf;
            s2_reg   <= 11'h1bf;
            prev_reg <= 3'h1;
        end else if (i_clk_en) begin
            s1_reg   <= async_in;
            s2_reg   <= s1_reg;
            prev_reg <= {s2_reg[10], s2_reg[9], s2_reg[5]};
        end
    end
    wire cclk_s   = s2_reg[10];
    wire tck_s    = s2_reg[9];
    wire tms_s    = s2_reg[8];
    wire tdi_s    = s2_reg[7];
    wire busy_s   = s2_reg[6];
    wire pick_n_s = s2_reg[4];
    wire [1:0] rev_pin_s = s2_reg[3:2];
    wire active   = !s2_reg[1] & s2_reg[0];
    wire cclk_rise = cclk_s & !prev_reg[2];
    wire tck_rise  = tck_s & !prev_reg[1];
    wire tck_fall  = !tck_s & prev_reg[1];
    wire cf_rise   = s2_reg[5] & !prev_reg[0];

    // ----------------------------------------
    // APB registers and storage
    // ----------------------------------------
    cprc_ctrl_type   ctrl_reg;
    logic [MAW-1:0]  term_reg, maddr_reg;
    logic [7:0]      store_reg [2**MAW];
    logic [MAW:0]    acnt_reg;
    logic [1:0]      rev_reg;
    wire apb_acc  = i_psel & i_penable & !o_pready;
    wire apb_wr   = apb_acc & i_pwrite;
    wire hit_ctrl = (i_paddr == CTRL_OFS);
    wire hit_term = (i_paddr == TERM_OFS);
    wire hit_madr = (i_paddr == MADDR_OFS);
    wire hit_mdat = (i_paddr == MDATA_OFS);
    wire hit_stat = (i_paddr == STAT_OFS);
    wire hit_any  = hit_ctrl | hit_term | hit_madr | hit_mdat | hit_stat;
    wire [31:0] rd_mux =
        hit_ctrl ? {26'h0, ctrl_reg} :
        hit_term ? 32'(term_reg) :
        hit_madr ? 32'(maddr_reg) :
        hit_mdat ? {24'h0, store_reg[maddr_reg]} :
        hit_stat ? (32'(acnt_reg) | (32'(rev_reg) << STAT_REV_LSB)
                    | (32'(o_chain_enable_out_n) << STAT_CHAIN_BIT)
                    | (32'(active) << STAT_ACT_BIT)) : 32'h0;
    // Storage load
    always_ff @(posedge i_mclk) begin
        if (i_clk_en && apb_wr && hit_mdat) begin
            store_reg[maddr_reg] <= i_pwdata[7:0];
        end
    end
    // Bus answer after one wait state
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_reg  <= CTRL_RST;
            term_reg  <= '0;
            maddr_reg <= '0;
            o_prdata  <= 32'h0;
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end else if (i_clk_en) begin
            o_pready  <= apb_acc;
            o_pslverr <= apb_acc & !hit_any;
            o_prdata  <= (apb_acc & !i_pwrite) ? rd_mux : 32'h0;
            if (apb_wr && hit_ctrl) ctrl_reg <= i_pwdata[CTRL_W-1:0];
            if (apb_wr && hit_term) term_reg <= i_pwdata[MAW-1:0];
            if (apb_wr && hit_madr) maddr_reg <= i_pwdata[MAW-1:0];
            else if (apb_wr && hit_mdat) maddr_reg <= MAW'(maddr_reg + 1'b1);
        end
    end

    // ----------------------------------------
    // Revision selection and restart
    // ----------------------------------------
    wire [1:0] rev_pick = pick_n_s ? ctrl_reg.rev : rev_pin_s;
    wire restart = !active | cf_rise;
    wire [1:0] rev_next = cf_rise ? rev_pick : rev_reg;
    wire [MAW:0] base = (MAW+1)'(rev_next) << (MAW - 2);

    // ----------------------------------------
    // Clock source and prefetch
    // ----------------------------------------
    logic [7:0] osc_cnt_reg;
    logic       osc_reg;
    wire osc_wrap  = (osc_cnt_reg == 8'(OSC_HALF_CYC - 1));
    wire osc_next  = osc_wrap ? !osc_reg : osc_reg;
    wire src_rise  = ctrl_reg.ext_clk ? cclk_rise : (osc_wrap & !osc_reg);
    wire src_level = ctrl_reg.ext_clk ? cclk_s : osc_next;
    logic [MAW:0] fptr_reg;
    logic         f_ready, f_valid;
    logic [7:0]   f_data;
    logic         load;
    wire fetch_ok = active & !restart & (fptr_reg <= (MAW+1)'(term_reg));
    // Oscillator and prefetch pointer
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            osc_cnt_reg <= 8'h00;
            osc_reg     <= 1'b0;
            fptr_reg    <= '0;
        end else if (i_clk_en) begin
            osc_cnt_reg <= osc_wrap ? 8'h00 : 8'(osc_cnt_reg + 1'b1);
            osc_reg     <= osc_next;
            if (restart) fptr_reg <= base;
            else if (fetch_ok && f_ready) fptr_reg <= (MAW+1)'(fptr_reg + 1'b1);
        end
    end
    cprc_fifo #(.W(8), .D(FIFO_D)) u_fifo (
        .i_mclk     (i_mclk),
        .i_rst      (i_rst),
        .i_clk_en   (i_clk_en),
        .i_flush    (restart),
        .i_in_valid (fetch_ok),
        .o_in_ready (f_ready),
        .i_in_data  (store_reg[fptr_reg[MAW-1:0]]),
        .o_out_valid(f_valid),
        .i_out_ready(load),
        .o_out_data (f_data)
    );

    // ----------------------------------------
    // Readout stepping
    // ----------------------------------------
    logic [7:0] shf_reg;
    logic [2:0] bit_reg;
    wire busy_eff = busy_s & !ctrl_reg.serial & !ctrl_reg.decomp;
    wire step  = src_rise & active & !restart & !busy_eff;
    assign load = step & f_valid & (!ctrl_reg.serial | bit_reg == 3'h0);
    wire shift = step & ctrl_reg.serial & (bit_reg != 3'h0);
    wire [MAW:0] acnt_next = restart ? base :
                             load ? (MAW+1)'(acnt_reg + 1'b1) : acnt_reg;
    wire [7:0] shf_next = load ? f_data :
                          shift ? {shf_reg[6:0], 1'b0} : shf_reg;
    wire past_tc = (acnt_next > (MAW+1)'(term_reg));
    wire starved = ctrl_reg.decomp & !f_valid & (bit_reg == 3'h0);
    // Counter, data and pin drivers
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            acnt_reg <= '0;
            rev_reg  <= 2'h0;
            shf_reg  <= 8'h00;
            bit_reg  <= 3'h0;
            o_data   <= 8'h00;
            o_data_oe <= 8'h00;
            o_forwarded_config_clock    <= 1'b0;
            o_forwarded_config_clock_oe <= 1'b0;
            o_chain_enable_out_n <= 1'b1;
        end else if (i_clk_en) begin
            acnt_reg <= acnt_next;
            rev_reg  <= rev_next;
            shf_reg  <= shf_next;
            if (restart) bit_reg <= 3'h0;
            else if (load && ctrl_reg.serial) bit_reg <= 3'h1;
            else if (shift) bit_reg <= 3'(bit_reg + 1'b1);
            o_data <= ctrl_reg.serial ? {7'h00, shf_next[7]} : shf_next;
            o_data_oe <= active ? (ctrl_reg.serial ? 8'h01 : 8'hff) : 8'h00;
            o_forwarded_config_clock <= src_level & !starved;
            o_forwarded_config_clock_oe <= ctrl_reg.fwd_en & active;
            o_chain_enable_out_n <= !(active & past_tc);
        end
    end

    // ----------------------------------------
    // Own drive of the reset line
    // ----------------------------------------
    logic [7:0] hold_reg;
    // Pull line low after reset
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            hold_reg       <= 8'(RST_HOLD_CYC);
            o_oe_rst_oe    <= 1'b1;
            o_oe_rst_n_out <= 1'b0;
        end else if (i_clk_en) begin
            hold_reg       <= (hold_reg != 8'h00) ? 8'(hold_reg - 1'b1) : 8'h00;
            o_oe_rst_oe    <= (hold_reg > 8'h01);
            o_oe_rst_n_out <= 1'b0;
        end
    end

    // ----------------------------------------
    // Test access port
    // ----------------------------------------
    function automatic cprc_tap_type tap_next(input cprc_tap_type s, input logic m);
        unique case (s)
            TAP_TLR: tap_next = m ? TAP_TLR : TAP_RTI;
            TAP_RTI: tap_next = m ? TAP_SDR : TAP_RTI;
            TAP_SDR: tap_next = m ? TAP_SIR : TAP_CDR;
            TAP_CDR: tap_next = m ? TAP_E1D : TAP_HDR;
            TAP_HDR: tap_next = m ? TAP_E1D : TAP_HDR;
            TAP_E1D: tap_next = m ? TAP_UDR : TAP_PDR;
            TAP_PDR: tap_next = m ? TAP_E2D : TAP_PDR;
            TAP_E2D: tap_next = m ? TAP_UDR : TAP_HDR;
            TAP_UDR: tap_next = m ? TAP_SDR : TAP_RTI;
            TAP_SIR: tap_next = m ? TAP_TLR : TAP_CIR;
            TAP_CIR: tap_next = m ? TAP_E1I : TAP_HIR;
            TAP_HIR: tap_next = m ? TAP_E1I : TAP_HIR;
            TAP_E1I: tap_next = m ? TAP_UIR : TAP_PIR;
            TAP_PIR: tap_next = m ? TAP_E2I : TAP_PIR;
            TAP_E2I: tap_next = m ? TAP_UIR : TAP_HIR;
            TAP_UIR: tap_next = m ? TAP_SDR : TAP_RTI;
            default: tap_next = TAP_TLR;
        endcase
    endfunction : tap_next
    cprc_tap_type tap_reg;
    logic [IR_W-1:0] ir_reg, irs_reg;
    logic [31:0]     drs_reg;
    wire bypass = (ir_reg != IR_IDCODE);
    // Test port on test clock edges
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            tap_reg  <= TAP_TLR;
            ir_reg   <= IR_IDCODE;
            irs_reg  <= 8'h00;
            drs_reg  <= 32'h0;
            o_tdo    <= 1'b1;
            o_tdo_oe <= 1'b0;
        end else if (i_clk_en) begin
            if (tck_rise) begin
                tap_reg <= tap_next(tap_reg, tms_s);
                if (tap_reg == TAP_TLR) ir_reg <= IR_IDCODE;
                if (tap_reg == TAP_UIR) ir_reg <= irs_reg;
                if (tap_reg == TAP_CIR) irs_reg <= IR_CAPTURE;
                if (tap_reg == TAP_HIR) irs_reg <= {tdi_s, irs_reg[IR_W-1:1]};
                if (tap_reg == TAP_CDR) drs_reg <= bypass ? 32'h0 : ID_VALUE;
                if (tap_reg == TAP_HDR) begin
                    drs_reg <= bypass ? {31'h0, tdi_s} : {tdi_s, drs_reg[31:1]};
                end
            end
            if (tck_fall) begin
                o_tdo    <= (tap_reg == TAP_HIR) ? irs_reg[0] : drs_reg[0];
                o_tdo_oe <= (tap_reg == TAP_HIR) | (tap_reg == TAP_HDR);
            end
        end
    end
endmodule : cprc_top

// ==== testbench/cprc_chk.sv ====
// Port checker of the readout block
`timescale 1ns/10ps
module cprc_chk (
    // Clock and reset
    input wire logic        i_mclk,
    input wire logic        i_rst,
    // APB
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    // Configuration pins
    input wire logic        i_chip_en_n,
    input wire logic        i_oe_rst_n,
    input wire logic        o_oe_rst_n_out,
    input wire logic        o_oe_rst_oe,
    input wire logic [7:0]  o_data,
    input wire logic [7:0]  o_data_oe,
    input wire logic        o_forwarded_config_clock,
    input wire logic        o_forwarded_config_clock_oe,
    input wire logic        o_chain_enable_out_n
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    wire sel_ok = !i_chip_en_n && i_oe_rst_n;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    property p_apb_wait; i_psel && i_penable && !o_pready |=> o_pready; endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("pready late");
    property p_apb_pulse; o_pready |=> !o_pready; endproperty
    a_apb_pulse: assert property (p_apb_pulse) else $error("pready too long");
    property p_apb_idle; !o_pready |-> o_prdata == 32'h0 && !o_pslverr; endproperty
    a_apb_idle: assert property (p_apb_idle) else $error("read bus not quiet");
    property p_chain_off;
        (i_chip_en_n || !i_oe_rst_n) [*4] |-> o_chain_enable_out_n;
    endproperty
    a_chain_off: assert property (p_chain_off) else $error("chain stays low");
    property p_chain_on;
        !o_chain_enable_out_n |-> $past(sel_ok, 2) || $past(sel_ok, 3) || $past(sel_ok, 4);
    endproperty
    a_chain_on: assert property (p_chain_on) else $error("chain low unselected");
    property p_float_ce;
        i_chip_en_n [*4] |-> !o_forwarded_config_clock_oe && o_data_oe == 8'h00;
    endproperty
    a_float_ce: assert property (p_float_ce) else $error("drives in standby");
    property p_float_rst;
        !i_oe_rst_n [*4] |-> !o_forwarded_config_clock_oe && o_data_oe == 8'h00;
    endproperty
    a_float_rst: assert property (p_float_rst) else $error("drives in reset");
    property p_drive_rst; $fell(i_rst) |-> (o_oe_rst_oe && !o_oe_rst_n_out) [*8]; endproperty
    a_drive_rst: assert property (p_drive_rst) else $error("reset line released");
    property p_align;
        $changed(o_data) && o_forwarded_config_clock_oe && $past(o_forwarded_config_clock_oe)
            |-> $rose(o_forwarded_config_clock);
    endproperty
    a_align: assert property (p_align) else $error("data off clock edge");
endmodule : cprc_chk

bind cprc_top cprc_chk cprc_chk_i (.*);

// ==== testbench/cprc_fpga.sv ====
// Configuration-side model: link clock and capture
`timescale 1ns/10ps
module cprc_fpga (
    // Clock and frame control
    input  wire logic       i_mclk,
    input  wire logic       i_run,
    // Link pins
    output logic            o_cfg_clk,
    input  wire logic [7:0] i_data,
    input  wire logic [7:0] i_data_oe,
    input  wire logic       i_fwd_clk,
    input  wire logic       i_fwd_oe,
    input  wire logic       i_busy,
    input  wire logic       i_chain_n
);
    logic [7:0] got[$];
    logic [1:0] bh     = 2'h3;
    logic       chn_l  = 1'b1;
    logic [7:0] data_w;
    logic [7:0] data_l = 8'h00;
    logic       fwd_w;
    logic       fwd_l  = 1'b1;
    // Pull-up on clock, floating data flips
    assign fwd_w  = i_fwd_oe ? i_fwd_clk : 1'b1;
    assign data_w = (i_data & i_data_oe) | (~data_l & ~i_data_oe);
    // Link clock of 200 ns, still between frames
    initial begin
        o_cfg_clk = 1'b0;
        #37;
        forever begin
            #100;
            o_cfg_clk = i_run ? ~o_cfg_clk : 1'b0;
        end
    end
    // Capture on forwarded clock rise, not while busy or, while data bit 1 is driven (parallel mode), past chain hand-off
    always @(posedge i_mclk) begin
        if (fwd_w && !fwd_l && i_fwd_oe && !i_busy && bh == 2'h0
            && (chn_l || !i_data_oe[1])) begin
            got.push_back(data_w);
        end
        bh     <= {bh[0], i_busy};
        chn_l  <= i_chain_n;
        fwd_l  <= fwd_w;
        data_l <= data_w;
    end
endmodule : cprc_fpga

// ==== testbench/tb.sv ====
// Self-checking bench of the readout block
`timescale 1ns/10ps
module tb
    import cprc_pkg::*;
;
    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    logic i_mclk = 1'b0, i_clk_en = 1'b1, i_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0;
    logic i_pwrite = 1'b0, i_chip_en_n = 1'b1, i_busy = 1'b0, i_config_pulse_n = 1'b1;
    logic i_external_revision_pick_n = 1'b1, i_revision_pin_bit0 = 1'b1;
    logic i_revision_pin_bit1 = 1'b1, i_tck = 1'b0, i_tms = 1'b1, i_tdi = 1'b1;
    logic oe_hold = 1'b0, run = 1'b0, err, tdo_s;
    logic [7:0]  i_paddr = 8'h00, o_data, o_data_oe;
    logic [31:0] i_pwdata = 32'h0, o_prdata, rdv;
    logic o_pready, o_pslverr, i_cfg_clk, i_oe_rst_n, o_oe_rst_n_out, o_oe_rst_oe, o_tdo;
    logic o_forwarded_config_clock, o_forwarded_config_clock_oe, o_chain_enable_out_n, o_tdo_oe;
    int   mismatches = 0, cmp_count = 0, cyc = 0;
    always #12.5 i_mclk = ~i_mclk;
    // Open-drain reset line with pull-up
    assign i_oe_rst_n = ((o_oe_rst_oe && !o_oe_rst_n_out) || oe_hold) ? 1'b0 : 1'b1;
    cprc_top cprc_top_i (.*);
    cprc_fpga cprc_fpga_i (.i_mclk(i_mclk), .i_run(run), .o_cfg_clk(i_cfg_clk),
        .i_data(o_data), .i_data_oe(o_data_oe), .i_fwd_clk(o_forwarded_config_clock),
        .i_fwd_oe(o_forwarded_config_clock_oe), .i_busy(i_busy & o_data_oe[1]),
        .i_chain_n(o_chain_enable_out_n));
    // Bench tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic cyc_n(input int n);
        repeat (n) @(posedge i_mclk);
    endtask : cyc_n
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_psel   <= 1'b1;
        i_pwrite <= w;
        i_paddr  <= a;
        i_pwdata <= d;
        @(posedge i_mclk);
        i_penable <= 1'b1;
        do @(posedge i_mclk); while (o_pready !== 1'b1);
        rdv = o_prdata;
        err = o_pslverr;
        i_psel    <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb
    task automatic pulse();
        @(posedge i_mclk);
        i_config_pulse_n <= 1'b0;
        cyc_n(6);
        i_config_pulse_n <= 1'b1;
        cyc_n(6);
    endtask : pulse
    task automatic tk(input logic m, input logic d);
        @(posedge i_mclk);
        i_tms <= m;
        i_tdi <= d;
        cyc_n(4);
        tdo_s = o_tdo;
        i_tck <= 1'b1;
        cyc_n(4);
        i_tck <= 1'b0;
    endtask : tk
    task automatic stop_link();
        @(posedge i_mclk);
        run         <= 1'b0;
        i_busy      <= 1'b0;
        i_chip_en_n <= 1'b1;
        cyc_n(6);
        cprc_fpga_i.got.delete();
    endtask : stop_link
    // Scenarios
    task automatic t_regs();
        apb(1'b0, CTRL_OFS, 32'h0);
        chk("ctrl reset", {26'h0, CTRL_RST}, rdv);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rdv);
        apb(1'b1, MADDR_OFS, 32'h0);
        for (int i = 0; i < 8; i++) apb(1'b1, MDATA_OFS, 32'h30 + i);
        apb(1'b1, MADDR_OFS, 32'h3);
        apb(1'b0, MDATA_OFS, 32'h0);
        chk("stored byte", 32'h33, rdv & 32'hff);
    endtask : t_regs
    task automatic t_par();
        int n;
        apb(1'b1, TERM_OFS, 32'h5);
        apb(1'b1, CTRL_OFS, 32'h0c);
        i_chip_en_n <= 1'b0;
        run         <= 1'b1;
        for (int k = 0; k < 400 && cprc_fpga_i.got.size() < 2; k++) @(posedge i_mclk);
        i_busy <= 1'b1;
        cyc_n(16);
        n = cprc_fpga_i.got.size();
        cyc_n(80);
        chk("busy count", n, cprc_fpga_i.got.size());
        chk("busy data", 32'h30 + n - 1, o_data);
        i_busy <= 1'b0;
        for (int k = 0; k < 400 && cprc_fpga_i.got.size() == n; k++) @(posedge i_mclk);
        chk("after busy", 32'h30 + n, cprc_fpga_i.got[n]);
        for (int k = 0; k < 800 && o_chain_enable_out_n !== 1'b0; k++) @(posedge i_mclk);
        chk("chain low", 32'h0, o_chain_enable_out_n);
        cyc_n(40);
        chk("byte count", 32'h6, cprc_fpga_i.got.size());
        foreach (cprc_fpga_i.got[i]) chk("byte", 32'h30 + i, cprc_fpga_i.got[i]);
        stop_link();
        chk("chain off", 32'h1, o_chain_enable_out_n);
        chk("data float", 32'h0, o_data_oe);
    endtask : t_par
    task automatic t_ser();
        apb(1'b1, TERM_OFS, 32'h0);
        apb(1'b1, CTRL_OFS, 32'h14);
        i_busy      <= 1'b1;
        oe_hold     <= 1'b1;
        i_chip_en_n <= 1'b0;
        cyc_n(8);
        chk("reset float", 32'h0, o_data_oe);
        oe_hold <= 1'b0;
        for (int k = 0; k < 400 && cprc_fpga_i.got.size() < 1; k++) @(posedge i_mclk);
        chk("serial drive", 32'h1, o_data_oe);
        for (int k = 0; k < 900 && cprc_fpga_i.got.size() < 8; k++) @(posedge i_mclk);
        for (int i = 0; i < 8; i++) chk("bit", (32'h30 >> (7 - i)) & 32'h1,
            {31'h0, cprc_fpga_i.got[i][0]});
        stop_link();
        apb(1'b1, CTRL_OFS, 32'h08);
        i_chip_en_n <= 1'b0;
        run         <= 1'b1;
        cyc_n(120);
        chk("fwd off", 32'h0, {31'h0, o_forwarded_config_clock_oe});
        stop_link();
    endtask : t_ser
    task automatic t_rev();
        for (int r = 0; r < 4; r++) begin
            i_external_revision_pick_n <= 1'b0;
            {i_revision_pin_bit1, i_revision_pin_bit0} <= r[1:0];
            pulse();
            apb(1'b0, STAT_OFS, 32'h0);
            chk("pin revision", r, rdv[17:16]);
            chk("revision base", r << 10, rdv[12:0]);
        end
        i_external_revision_pick_n <= 1'b1;
        apb(1'b1, CTRL_OFS, 32'h05);
        pulse();
        apb(1'b0, STAT_OFS, 32'h0);
        chk("bit revision", 32'h1, rdv[17:16]);
    endtask : t_rev
    task automatic t_tap();
        logic [8:0] walk = 9'b0_0101_1111;
        for (int i = 0; i < 9; i++) tk(walk[i], 1'b1);
        for (int i = 0; i < 40; i++) begin
            tk(1'b0, 1'b1);
            chk("tdo bit", (i < 32) ? ID_VALUE[i] : 1'b1, tdo_s);
        end
        chk("tdo drive", 32'h1, o_tdo_oe);
    endtask : t_tap
    // Verdict
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done
    // Cycle ceiling
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            mismatches++;
            test_done();
        end
    end
    // Main sequence
    initial begin
        cyc_n(3);
        i_rst <= 1'b0;
        for (int k = 0; k < RST_HOLD_CYC + 8 && o_oe_rst_oe !== 1'b0; k++) @(posedge i_mclk);
        chk("reset drive end", 32'h0, o_oe_rst_oe);
        t_regs();
        t_par();
        t_ser();
        t_rev();
        t_tap();
        test_done();
    end
endmodule : tb
